// ==== eip_flags.sv ====
`timescale 1ns/1ps
// Peripheral flags: a set pulse stays pending until cleared
module eip_flags (
    input wire logic ref_clk,
    input wire logic [10:0] set,
    input wire logic [10:0] clr,
    output logic [10:0] flag
);
    logic [10:0] pend_r;
    // Kept outside the controller, so a masked flag is not lost
    always_ff @(posedge ref_clk) pend_r <= (pend_r | set) & ~clr;
    assign flag = pend_r | set;
endmodule

// ==== eip_gate.sv ====
`timescale 1ns/1ps
// Masks raw source levels and splits them by priority level
module eip_gate (
    input wire logic [7:0] raw_req,
    input wire logic [7:0] enable,
    input wire logic [7:0] priority_sel,
    output logic [7:0] req_high,
    output logic [7:0] req_low
);
    genvar g;
    // Masking only blocks the request; the source flag itself is untouched
    generate
        for (g = 0; g < eip_pkg::NUM_SRC; g++) begin : g_src
            assign req_high[g] = raw_req[g] & enable[g] & priority_sel[g];
            assign req_low[g] = raw_req[g] & enable[g] & ~priority_sel[g];
        end
    endgenerate
endmodule

// ==== eip_pkg.sv ====
package eip_pkg;
    // Special-function addresses, decoded on every page
    localparam logic [7:0] ENABLE_ONE_ADDR = 8'he6;
    localparam logic [7:0] PRIORITY_ONE_ADDR = 8'hf6;
    localparam logic [7:0] ENABLE_ONE_RESET = 8'h00;
    localparam logic [7:0] PRIORITY_ONE_RESET = 8'h00;
    // Source positions, shared by both registers
    localparam int SRC_TWO_WIRE = 0;
    localparam int SRC_RTC_ALARM = 1;
    localparam int SRC_WINDOW_CMP = 2;
    localparam int SRC_CONV_DONE = 3;
    localparam int SRC_COUNTER_ARRAY = 4;
    localparam int SRC_CMP_ZERO = 5;
    localparam int SRC_CMP_ONE = 6;
    localparam int SRC_TIMER_THREE = 7;
    localparam int NUM_SRC = 8;
endpackage

// ==== eip_sfr_reg.sv ====
`timescale 1ns/1ps
// One 8-bit read/write special-function register
module eip_sfr_reg #(
    parameter logic [7:0] ADDR = 8'h00,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic ref_clk,
    input wire logic rst_sync_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] value,
    output logic hit
);
    logic [7:0] value_r;
    logic [7:0] value_nxt;

    // Page bits are not looked at, so the register answers on every page
    assign hit = (sfr_addr == ADDR);
    assign value = value_r;

    // Next value
    always_comb begin
        value_nxt = value_r;
        if (sfr_wr && hit) begin
            value_nxt = sfr_wdata;
        end
    end

    // Register
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            value_r <= RESET_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end
endmodule

// ==== eip_top.sv ====
`timescale 1ns/1ps
module eip_top (
    // Clock and external reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_sel,
    // Request flags from the peripherals
    input wire logic timer_three_low_overflow,
    input wire logic timer_three_high_overflow,
    input wire logic cmp_one_rise_flag,
    input wire logic cmp_one_fall_flag,
    input wire logic cmp_zero_rise_flag,
    input wire logic cmp_zero_fall_flag,
    input wire logic counter_array_req,
    input wire logic conv_done_flag,
    input wire logic window_cmp_flag,
    input wire logic rtc_alarm_req,
    input wire logic two_wire_req,
    // Masked requests to the core, one vector per level
    output logic [7:0] irq_high,
    output logic [7:0] irq_low
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser stages
    logic rst_meta_r;
    logic rst_meta_nxt;
    logic rst_sync_r;
    logic rst_sync_nxt;

    // Register values and address hits
    logic [7:0] enable_val;
    logic [7:0] prio_val;
    logic enable_hit;
    logic prio_hit;

    // One merged request line per source
    logic timer_three_src;
    logic cmp_one_src;
    logic cmp_zero_src;
    logic counter_array_src;
    logic conv_done_src;
    logic window_cmp_src;
    logic rtc_alarm_src;
    logic two_wire_src;

    // Enable field per source
    logic timer_three_irq_en;
    logic cmp_one_irq_en;
    logic cmp_zero_irq_en;
    logic counter_array_irq_en;
    logic conv_done_irq_en;
    logic window_cmp_irq_en;
    logic rtc_alarm_irq_en;
    logic two_wire_irq_en;

    // Priority field per source
    logic timer_three_irq_prio;
    logic cmp_one_irq_prio;
    logic cmp_zero_irq_prio;
    logic counter_array_irq_prio;
    logic conv_done_irq_prio;
    logic window_cmp_irq_prio;
    logic rtc_alarm_irq_prio;
    logic two_wire_irq_prio;

    // Vectors in source order
    logic [7:0] raw_req;
    logic [7:0] enable_sel;
    logic [7:0] prio_sel;
    logic [7:0] req_high;
    logic [7:0] req_low;

    // Read-back and request state
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] irq_high_r;
    logic [7:0] irq_high_nxt;
    logic [7:0] irq_low_r;
    logic [7:0] irq_low_nxt;

    // Places one bit per source at its position; all three vectors share it
    function automatic logic [7:0] pack_sources(
        input logic timer_three,
        input logic cmp_one,
        input logic cmp_zero,
        input logic counter_array,
        input logic conv_done,
        input logic window_cmp,
        input logic rtc_alarm,
        input logic two_wire
    );
        logic [7:0] bits_v;
        bits_v = 8'h00;
        bits_v[eip_pkg::SRC_TIMER_THREE] = timer_three;
        bits_v[eip_pkg::SRC_CMP_ONE] = cmp_one;
        bits_v[eip_pkg::SRC_CMP_ZERO] = cmp_zero;
        bits_v[eip_pkg::SRC_COUNTER_ARRAY] = counter_array;
        bits_v[eip_pkg::SRC_CONV_DONE] = conv_done;
        bits_v[eip_pkg::SRC_WINDOW_CMP] = window_cmp;
        bits_v[eip_pkg::SRC_RTC_ALARM] = rtc_alarm;
        bits_v[eip_pkg::SRC_TWO_WIRE] = two_wire;
        return bits_v;
    endfunction

    // Reset release: two stages, so the release never lands mid-edge
    always_comb begin
        rst_meta_nxt = 1'b1;
        rst_sync_nxt = rst_meta_r;
    end

    // Assertion stays asynchronous; only the release is retimed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= rst_meta_nxt;
            rst_sync_r <= rst_sync_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable register, one bit per source
    eip_sfr_reg #(
        .ADDR(eip_pkg::ENABLE_ONE_ADDR),
        .RESET_VAL(eip_pkg::ENABLE_ONE_RESET)
    ) u_extended_irq_enable_one (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_r),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .value(enable_val),
        .hit(enable_hit)
    );

    // Priority register, same bit layout as the enable register
    eip_sfr_reg #(
        .ADDR(eip_pkg::PRIORITY_ONE_ADDR),
        .RESET_VAL(eip_pkg::PRIORITY_ONE_RESET)
    ) u_extended_irq_priority_one (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_r),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .value(prio_val),
        .hit(prio_hit)
    );

    // Bus select: either register answers its address
    assign sfr_sel = enable_hit | prio_hit;

    // Read data registered; unmapped addresses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            if (enable_hit) begin
                rdata_nxt = enable_val;
            end else if (prio_hit) begin
                rdata_nxt = prio_val;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral side: merged request, enable field and level per source
    // Timer three: either overflow half raises the one request
    // Both halves share one enable bit and one level
    assign timer_three_src = timer_three_low_overflow | timer_three_high_overflow;
    assign timer_three_irq_en = enable_val[eip_pkg::SRC_TIMER_THREE];
    assign timer_three_irq_prio = prio_val[eip_pkg::SRC_TIMER_THREE];

    // Comparator one: rising or falling edge flag
    // Software must clear both flags to drop the request
    assign cmp_one_src = cmp_one_rise_flag | cmp_one_fall_flag;
    assign cmp_one_irq_en = enable_val[eip_pkg::SRC_CMP_ONE];
    assign cmp_one_irq_prio = prio_val[eip_pkg::SRC_CMP_ONE];

    // Comparator zero: rising or falling edge flag
    // Same pairing as comparator one, one bit lower
    assign cmp_zero_src = cmp_zero_rise_flag | cmp_zero_fall_flag;
    assign cmp_zero_irq_en = enable_val[eip_pkg::SRC_CMP_ZERO];
    assign cmp_zero_irq_prio = prio_val[eip_pkg::SRC_CMP_ZERO];

    // Counter array: all of its channels arrive as one merged level
    // Masking here leaves the channel flags pending in the array
    assign counter_array_src = counter_array_req;
    assign counter_array_irq_en = enable_val[eip_pkg::SRC_COUNTER_ARRAY];
    assign counter_array_irq_prio = prio_val[eip_pkg::SRC_COUNTER_ARRAY];

    // Conversion complete from the analog converter
    // Kept apart from the window request so each has its own level
    assign conv_done_src = conv_done_flag;
    assign conv_done_irq_en = enable_val[eip_pkg::SRC_CONV_DONE];
    assign conv_done_irq_prio = prio_val[eip_pkg::SRC_CONV_DONE];

    // Window compare from the analog converter
    // A result inside or outside the window is decided upstream
    assign window_cmp_src = window_cmp_flag;
    assign window_cmp_irq_en = enable_val[eip_pkg::SRC_WINDOW_CMP];
    assign window_cmp_irq_prio = prio_val[eip_pkg::SRC_WINDOW_CMP];

    // Real-time clock alarm, already in this clock domain
    // The alarm source holds its level until software clears it
    assign rtc_alarm_src = rtc_alarm_req;
    assign rtc_alarm_irq_en = enable_val[eip_pkg::SRC_RTC_ALARM];
    assign rtc_alarm_irq_prio = prio_val[eip_pkg::SRC_RTC_ALARM];

    // Two-wire port: all of its causes arrive as one merged level
    // Lowest bit of both registers
    assign two_wire_src = two_wire_req;
    assign two_wire_irq_en = enable_val[eip_pkg::SRC_TWO_WIRE];
    assign two_wire_irq_prio = prio_val[eip_pkg::SRC_TWO_WIRE];

    // Source-ordered vectors for the gate
    assign raw_req = pack_sources(
        timer_three_src,
        cmp_one_src,
        cmp_zero_src,
        counter_array_src,
        conv_done_src,
        window_cmp_src,
        rtc_alarm_src,
        two_wire_src
    );
    assign enable_sel = pack_sources(
        timer_three_irq_en,
        cmp_one_irq_en,
        cmp_zero_irq_en,
        counter_array_irq_en,
        conv_done_irq_en,
        window_cmp_irq_en,
        rtc_alarm_irq_en,
        two_wire_irq_en
    );
    assign prio_sel = pack_sources(
        timer_three_irq_prio,
        cmp_one_irq_prio,
        cmp_zero_irq_prio,
        counter_array_irq_prio,
        conv_done_irq_prio,
        window_cmp_irq_prio,
        rtc_alarm_irq_prio,
        two_wire_irq_prio
    );

    // Mask and level split; bit n of priority pairs with bit n of enable
    eip_gate u_gate (
        .raw_req(raw_req),
        .enable(enable_sel),
        .priority_sel(prio_sel),
        .req_high(req_high),
        .req_low(req_low)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Core side: next request levels straight from the gate
    always_comb begin
        irq_high_nxt = req_high;
        irq_low_nxt = req_low;
    end

    // Outputs registered: one cycle of latency, but glitch-free to the core.
    // A masked flag is a level, so it reappears as soon as it is enabled.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rdata_r <= 8'h00;
            irq_high_r <= 8'h00;
            irq_low_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
            irq_high_r <= irq_high_nxt;
            irq_low_r <= irq_low_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign irq_high = irq_high_r;
    assign irq_low = irq_low_r;
endmodule

// ==== eip_top_assertions.sv ====
`timescale 1ns/1ps
module eip_top_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_sel,
    input wire logic timer_three_low_overflow,
    input wire logic timer_three_high_overflow,
    input wire logic cmp_one_rise_flag,
    input wire logic cmp_one_fall_flag,
    input wire logic cmp_zero_rise_flag,
    input wire logic cmp_zero_fall_flag,
    input wire logic counter_array_req,
    input wire logic conv_done_flag,
    input wire logic window_cmp_flag,
    input wire logic rtc_alarm_req,
    input wire logic two_wire_req,
    input wire logic [7:0] irq_high,
    input wire logic [7:0] irq_low
);
    logic [7:0] en_r, pr_r, raw, hx, lx;
    // Each source collapses to one request line
    assign raw = {timer_three_low_overflow | timer_three_high_overflow,
        cmp_one_rise_flag | cmp_one_fall_flag, cmp_zero_rise_flag | cmp_zero_fall_flag,
        counter_array_req, conv_done_flag, window_cmp_flag, rtc_alarm_req, two_wire_req};
    assign hx = raw & en_r & pr_r;
    assign lx = raw & en_r & ~pr_r;
    // Shadow copies, since the real registers are hidden
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) {en_r, pr_r} <= 16'h0000;
        else if (sfr_wr && sfr_addr == 8'he6) en_r <= sfr_wdata;
        else if (sfr_wr && sfr_addr == 8'hf6) pr_r <= sfr_wdata;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    high_path_a: assert property (irq_high == $past(hx)) else $error("bad high");
    low_path_a: assert property (irq_low == $past(lx)) else $error("bad low");
    timer_mask_a: assert property (!en_r[7] |=> !(irq_high[7] | irq_low[7]))
        else $error("timer unmasked");
    alarm_high_a: assert property (en_r[1] && pr_r[1] && rtc_alarm_req |=> irq_high[1])
        else $error("alarm level");
    cmp_one_mask_a: assert property (!en_r[6] |=> !(irq_high[6] | irq_low[6]))
        else $error("comparator unmasked");
    two_wire_low_a: assert property (en_r[0] && !pr_r[0] && two_wire_req |=> irq_low[0])
        else $error("two-wire level");
    read_enable_a: assert property (sfr_rd && sfr_addr == 8'he6 |=> sfr_rdata == $past(en_r))
        else $error("enable read");
    read_prio_a: assert property (sfr_rd && sfr_addr == 8'hf6 |=> sfr_rdata == $past(pr_r))
        else $error("priority read");
    unmapped_read_a: assert property (sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00)
        else $error("unmapped read");
    select_decode_a: assert property (sfr_sel == (sfr_addr == 8'he6 || sfr_addr == 8'hf6))
        else $error("select");
endmodule
bind eip_top eip_top_assertions eip_top_assertions_inst (.*);

// ==== test_extended_irq_enable_priority.sv ====
`timescale 1ns/1ps
module test_extended_irq_enable_priority;
    typedef struct {int at; logic [23:0] v;} eip_note_s;
    eip_note_s q[$];
    eip_note_s n;
    logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, sfr_sel;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, irq_high, irq_low;
    logic [7:0] em = 8'h00, pm = 8'h00, rm = 8'h00;
    logic [10:0] set = 11'h000, clr = 11'h7ff, flag, fl = 11'h000;
    logic [15:0] lf = 16'hb0d1;
    int cyc = 0, failures = 0, check_count = 0;
    eip_flags eip_flags_inst (.ref_clk, .set, .clr, .flag);
    eip_top eip_top_inst (.*, .timer_three_low_overflow(flag[10]),
        .timer_three_high_overflow(flag[9]), .cmp_one_rise_flag(flag[8]),
        .cmp_one_fall_flag(flag[7]), .cmp_zero_rise_flag(flag[6]), .cmp_zero_fall_flag(flag[5]),
        .counter_array_req(flag[4]), .conv_done_flag(flag[3]), .window_cmp_flag(flag[2]),
        .rtc_alarm_req(flag[1]), .two_wire_req(flag[0]));
    initial forever #20 ref_clk = ~ref_clk;
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // One cycle of stimulus; outputs are due after the following edge
    task automatic step(input logic w, r, input logic [7:0] a, d, input logic [10:0] s, c);
        logic [10:0] f;
        logic [7:0] g;
        @(posedge ref_clk);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, set, clr} <= {w, r, a, d, s, c};
        f = fl | s;
        g = {f[10] | f[9], f[8] | f[7], f[6] | f[5], f[4:0]} & em;
        if (r) rm = a == 8'he6 ? em : a == 8'hf6 ? pm : 8'h00;
        q.push_back('{cyc + 2, {g & pm, g & ~pm, rm}});
        em = w && a == 8'he6 ? d : em;
        pm = w && a == 8'hf6 ? d : pm;
        fl = f & ~c;
    endtask
    // Compare the oldest note once its edge has passed
    always @(negedge ref_clk) begin
        cyc++;
        if (q.size() > 0 && q[0].at == cyc) begin
            n = q.pop_front();
            check_count++;
            if ({irq_high, irq_low, sfr_rdata} !== n.v) begin
                failures++;
                $display("wrong value outputs expected %h seen %h", n.v,
                    {irq_high, irq_low, sfr_rdata});
            end
        end
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        step(0, 1, 8'he6, 8'h00, 11'h000, 11'h000);
        step(0, 1, 8'hf6, 8'h00, 11'h000, 11'h000);
        for (int i = 0; i < 500; i++) begin
            repeat (16) lf = nx(lf);
            step(lf[0], lf[1], lf[3] ? (lf[2] ? 8'he6 : 8'hf6) : lf[15:8], lf[11:4],
                lf[15:5] & lf[10:0], lf[14:4] & ~lf[12:2]);
        end
        step(0, 0, 8'h00, 8'h00, 11'h000, 11'h7ff);
        repeat (2) @(posedge ref_clk);
        if (q.size() != 0) failures++;
        wrap_up();
    end
endmodule
